/* logic/branch_status_ctl.sv */
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "branch_ctl_params.svh"
module branch_status_ctl
  import branch_ctl_pkg::*;
#(
  parameter int PAW = 8
) (
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [PAW-1:0] paddr,
  input  wire logic [31:0]    pwdata,
  output      logic [31:0]    prdata,
  output      logic           pready,
  output      logic           pslverr,
  // pipeline register fields
  input  wire logic [5:0]     low_instruction_bits,
  input  wire logic [2:0]     cond_sel,
  input  wire logic           branch_bit_d,
  input  wire logic           stack_enable_n,
  input  wire logic           push_pop,
  // live alu flags
  input  wire logic [3:0]     alu_flags,
  // external interrupt pin
  input  wire logic           hw_irq,
  // sequencer next-address source
  output      logic           next_src_sel_hi,
  output      logic           next_src_sel_lo,
  // visible state
  output      logic [3:0]     status_out,
  output      logic [3:0]     stack_ptr_out
);

  // registers
  flags_t      status_ff;
  ptr_t        ptr_ff;
  logic        wr_pend_ff;
  logic [31:0] mask_lo_ff;
  logic [31:0] mask_hi_ff;
  src_sel_t    src_ff;
  logic        irq_s1_ff;
  logic        irq_s2_ff;
  logic        irq_s3_ff;
  logic        irq_lvl_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        fwd_vld_ff;
  ptr_t        fwd_addr_ff;
  flags_t      fwd_data_ff;

  // next values
  flags_t      nxt_status;
  ptr_t        nxt_ptr;
  src_sel_t    nxt_src;

  // wires
  flags_t      stack_rd;
  flags_t      saved_status;
  logic        fwd_hit;
  logic [63:0] chg_mask;
  logic        status_chg;
  logic        sw_push;
  logic        sw_pop;
  logic        irq_rise;
  logic        do_push;
  logic        do_pop;
  logic        flag_z;
  logic        flag_n;
  logic        flag_c;
  logic        flag_v;
  logic [7:0]  hi_data;
  logic [7:0]  lo_data;
  logic        hi_bit;
  logic        lo_bit;

  // ---------------- interrupt pin synchroniser ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
      irq_s3_ff <= 1'b0;
    end else begin
      irq_s1_ff <= hw_irq;
      irq_s2_ff <= irq_s1_ff;
      irq_s3_ff <= irq_s2_ff;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_lvl_ff <= 1'b0;
    end else if (irq_s2_ff == irq_s3_ff) begin
      irq_lvl_ff <= irq_s2_ff;
    end
  end

  assign irq_rise = (irq_s2_ff == irq_s3_ff) && irq_s2_ff && !irq_lvl_ff;

  // ---------------- stack control decode ----------------
  assign sw_push = !stack_enable_n && push_pop;
  assign sw_pop  = !stack_enable_n && !push_pop;
  // an interrupt save beats a simultaneous software pop
  assign do_push = irq_rise || sw_push;
  assign do_pop  = sw_pop && !do_push;

  // ---------------- status register ----------------
  assign chg_mask   = {mask_hi_ff, mask_lo_ff};
  assign status_chg = chg_mask[low_instruction_bits];

  // a save still pending means the stack word is stale; take status
  // a save that landed at the last edge was missed by the registered read
  assign fwd_hit      = fwd_vld_ff && (fwd_addr_ff == ptr_ff);
  assign saved_status = wr_pend_ff ? status_ff :
                        fwd_hit    ? fwd_data_ff : stack_rd;

  always_comb begin
    nxt_status = status_ff;
    if (do_pop) begin
      nxt_status = saved_status;
    end else if (status_chg) begin
      nxt_status = alu_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= `RST_STATUS;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ---------------- stack pointer shift register ----------------
  // shifting keeps only the thermometer codes 0,1,3,7,15 reachable
  always_comb begin
    nxt_ptr = ptr_ff;
    if (do_push) begin
      nxt_ptr = {ptr_ff[2:0], 1'b1};
    end else if (do_pop) begin
      nxt_ptr = {1'b0, ptr_ff[3:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff     <= `RST_PTR;
      wr_pend_ff <= 1'b0;
    end else begin
      ptr_ff     <= nxt_ptr;
      wr_pend_ff <= do_push;
    end
  end

  // copy of the last save, for a pop one idle cycle behind a push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_vld_ff  <= 1'b0;
      fwd_addr_ff <= `RST_PTR;
      fwd_data_ff <= `RST_STATUS;
    end else begin
      fwd_vld_ff  <= wr_pend_ff;
      fwd_addr_ff <= ptr_ff;
      fwd_data_ff <= status_ff;
    end
  end

  // ---------------- save stack memory ----------------
  // read address runs one cycle ahead so the word is ready at a pop
  status_stack_mem #(
    .WIDTH (4),
    .DEPTH (16),
    .AW    (4)
  ) u_stack (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_en      (wr_pend_ff),
    .wr_addr    (ptr_ff),
    .wr_data    (status_ff),
    .rd_addr    (nxt_ptr),
    .rd_data_ff (stack_rd)
  );

  // ---------------- condition code multiplexers ----------------
  assign flag_z = status_ff[`FLAG_ZERO];
  assign flag_n = status_ff[`FLAG_SIGN];
  assign flag_c = status_ff[`FLAG_CARRY];
  assign flag_v = status_ff[`FLAG_OVFL];

  // inputs 0..5 from status, 6 and 7 from the pipeline bit d
  assign hi_data = {!branch_bit_d, !branch_bit_d,
                    flag_v, flag_c, flag_n, !flag_n,
                    flag_z, !flag_z};
  assign lo_data = {!branch_bit_d, branch_bit_d,
                    flag_v, flag_c, flag_n, !flag_n,
                    flag_z, !flag_z};

  cond_mux8 u_mux_hi (
    .sel  (cond_sel),
    .data (hi_data),
    .out  (hi_bit)
  );

  cond_mux8 u_mux_lo (
    .sel  (cond_sel),
    .data (lo_data),
    .out  (lo_bit)
  );

  // same data on both muxes for 0..5 gives 11 or 00 only
  assign nxt_src = src_sel_t'({hi_bit, lo_bit});

  // registered: the source select lags the pipeline fields one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ff <= SRC_PC;
    end else begin
      src_ff <= nxt_src;
    end
  end

  // ---------------- apb slave ----------------
  logic        apb_access;
  logic        apb_commit;
  logic        hit_lo;
  logic        hit_hi;
  logic        hit_state;
  logic        addr_hit;
  logic [31:0] rd_word;
  logic [31:0] state_word;

  assign apb_access = psel && penable;
  // a write lands only at the edge where pready is seen high
  assign apb_commit = apb_access && pready_ff && pwrite;
  assign hit_lo     = (paddr == `ADDR_CHG_MASK_LO);
  assign hit_hi     = (paddr == `ADDR_CHG_MASK_HI);
  assign hit_state  = (paddr == `ADDR_STATE);
  assign addr_hit   = hit_lo || hit_hi || hit_state;

  assign state_word = {24'h000000, ptr_ff, status_ff};
  assign rd_word    = hit_lo    ? mask_lo_ff :
                      hit_hi    ? mask_hi_ff :
                      hit_state ? state_word : 32'h00000000;

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (apb_access && !pready_ff) begin
      pready_ff  <= 1'b1;
      pslverr_ff <= !addr_hit;
      prdata_ff  <= pwrite ? 32'h00000000 : rd_word;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_lo_ff <= `RST_CHG_MASK;
      mask_hi_ff <= `RST_CHG_MASK;
    end else if (apb_commit && hit_lo) begin
      mask_lo_ff <= pwdata;
    end else if (apb_commit && hit_hi) begin
      mask_hi_ff <= pwdata;
    end
  end

  // ---------------- outputs ----------------
  assign next_src_sel_hi = src_ff[1];
  assign next_src_sel_lo = src_ff[0];
  assign status_out      = status_ff;
  assign stack_ptr_out   = ptr_ff;
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;

endmodule

/* logic/branch_ctl_params.svh */
// What this block does
// - status mux normally passes live ALU flags
// - status loads ALU flags only on status-changing instruction codes
// - pop loads status from the save stack
// - condition muxes: select, two inputs from pipeline
// - flags: zero, sign, carry, overflow
// - selects 0..5 test nz, z, nn, n, c, v
// - not-zero, not-negative true on clear flag
// - true gives 11, false gives 00
// - selects 6 and 7 with bit d force codes
// - 16x4 save stack, pointer is shift register
// - push shifts one in, writes status next cycle
// - pop restores status, shifts zero in
// - pointer saturates at 1111 and 0000
// - reset clears pointer to 0000
// - enable low and push high pushes, low pops
`ifndef BRANCH_CTL_PARAMS_SVH
`define BRANCH_CTL_PARAMS_SVH

`define ADDR_CHG_MASK_LO 8'h00
`define ADDR_CHG_MASK_HI 8'h04
`define ADDR_STATE       8'h08

`define RST_CHG_MASK     32'hFFFFFFFF
`define RST_STATUS       4'h0
`define RST_PTR          4'h0

`define FLAG_ZERO        0
`define FLAG_SIGN        1
`define FLAG_CARRY       2
`define FLAG_OVFL        3

`define STATE_PTR_LSB    4

`define SEL_FORCE_A      3'h6
`define SEL_FORCE_B      3'h7

`endif

/* logic/branch_ctl_pkg.sv */
package branch_ctl_pkg;

  // next-address source as the sequencer reads it, hi bit first
  typedef enum logic [1:0] {
    SRC_PC     = 2'h0,
    SRC_ADDR   = 2'h1,
    SRC_STACK  = 2'h2,
    SRC_DIRECT = 2'h3
  } src_sel_t;

  typedef logic [3:0] flags_t;
  typedef logic [3:0] ptr_t;

endpackage

/* logic/cond_mux8.sv */
`timescale 1ns/1ns
module cond_mux8 (
  // selection
  input  wire logic [2:0] sel,
  input  wire logic [7:0] data,
  // result
  output      logic       out
);

  assign out = data[sel];

endmodule

/* logic/status_stack_mem.sv */
`timescale 1ns/1ns
module status_stack_mem #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // registered read port
  input  wire logic [AW-1:0]    rd_addr,
  output      logic [WIDTH-1:0] rd_data_ff
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // cleared so that a pop beyond the bottom restores zeros, not x
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end

endmodule

/* dv/alu_flag_model.sv */
`timescale 1ns/1ns
module alu_flag_model (
  // operands of an add
  input  wire logic [15:0] opa,
  input  wire logic [15:0] opb,
  // flags, zero in bit 0
  output      logic [3:0]  flags
);
  logic [16:0] sum;
  assign sum = {1'h0, opa} + {1'h0, opb};
  assign flags = {opa[15] == opb[15] && sum[15] != opa[15],
                  sum[16], sum[15], sum[15:0] == 16'h0000};
endmodule

/* dv/branch_status_chk.sv */
`timescale 1ns/1ns
module branch_status_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // watched ports
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [2:0] cond_sel,
  input wire logic       branch_bit_d,
  input wire logic       stack_enable_n,
  input wire logic       push_pop,
  input wire logic [3:0] alu_flags,
  input wire logic       hw_irq,
  input wire logic       next_src_sel_hi,
  input wire logic       next_src_sel_lo,
  input wire logic [3:0] status_out,
  input wire logic [3:0] stack_ptr_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // late interrupt pushes would look like stray pointer moves
  logic [2:0] quiet_ff;
  wire        quiet = quiet_ff == 3'h7;
  wire  [1:0] src = {next_src_sel_hi, next_src_sel_lo};
  wire  [7:0] cv = {2'h0, status_out[3:2], status_out[1], !status_out[1],
                    status_out[0], !status_out[0]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_ff <= 3'h0;
    else if (hw_irq) quiet_ff <= 3'h0;
    else if (!quiet) quiet_ff <= quiet_ff + 3'h1;
  end
  sequence s_push;
    !stack_enable_n && push_pop;
  endsequence
  sequence s_pop;
    !stack_enable_n && !push_pop && quiet;
  endsequence
  property p_ptr_push;
    s_push |=> stack_ptr_out == {$past(stack_ptr_out[2:0]), 1'h1};
  endproperty
  a_ptr_push: assert property (p_ptr_push)
    else $error("pointer wrong after push");
  property p_ptr_pop;
    s_pop |=> stack_ptr_out == {1'h0, $past(stack_ptr_out[3:1])};
  endproperty
  a_ptr_pop: assert property (p_ptr_pop)
    else $error("pointer wrong after pop");
  property p_ptr_hold;
    stack_enable_n && quiet |=> $stable(stack_ptr_out);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("pointer moved while idle");
  property p_cond;
    cond_sel < 3'h6 |=> src == {2{$past(cv[cond_sel])}};
  endproperty
  a_cond: assert property (p_cond)
    else $error("conditional source wrong");
  property p_force;
    cond_sel > 3'h5 |=> src == {!$past(branch_bit_d),
                                $past(cond_sel[0] ^ branch_bit_d)};
  endproperty
  a_force: assert property (p_force)
    else $error("forced source wrong");
  property p_status_src;
    !$stable(status_out) && $past(stack_enable_n)
      |-> status_out == $past(alu_flags);
  endproperty
  a_status_src: assert property (p_status_src)
    else $error("status loaded from wrong source");
  property p_apb_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("ready not after one wait");
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse)
    else $error("ready longer than one cycle");
endmodule
bind branch_status_ctl branch_status_chk u_chk (
  .pclk            (pclk),
  .presetn         (presetn),
  .psel            (psel),
  .penable         (penable),
  .pready          (pready),
  .cond_sel        (cond_sel),
  .branch_bit_d    (branch_bit_d),
  .stack_enable_n  (stack_enable_n),
  .push_pop        (push_pop),
  .alu_flags       (alu_flags),
  .hw_irq          (hw_irq),
  .next_src_sel_hi (next_src_sel_hi),
  .next_src_sel_lo (next_src_sel_lo),
  .status_out      (status_out),
  .stack_ptr_out   (stack_ptr_out)
);

/* dv/branch_status_ctl_tb.sv */
`timescale 1ns/1ns
module branch_status_ctl_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, next_src_sel_hi, next_src_sel_lo;
  logic [5:0]  low_instruction_bits = 6'h00;
  // idle microcode carries the sequential forcing code
  logic [2:0]  cond_sel = 3'h7;
  logic        branch_bit_d = 1, stack_enable_n = 1, push_pop = 0, hw_irq = 0;
  logic [3:0]  alu_flags, status_out, stack_ptr_out;
  logic [15:0] opa = 16'h0, opb = 16'h0;
  int          mismatches = 0, samples_checked = 0, i;
  logic [15:0] ta [5] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000, 16'hFFFF};
  logic [15:0] tb2 [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0002};
  logic [3:0]  tf [5] = '{4'h1, 4'h5, 4'hA, 4'h2, 4'h4};
  logic [3:0]  pe [4] = '{4'h7, 4'h3, 4'h1, 4'h0};
  logic [3:0]  se [4] = '{4'h4, 4'hA, 4'h5, 4'h1};

  branch_status_ctl u_dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .low_instruction_bits (low_instruction_bits),
    .cond_sel             (cond_sel),
    .branch_bit_d         (branch_bit_d),
    .stack_enable_n       (stack_enable_n),
    .push_pop             (push_pop),
    .alu_flags            (alu_flags),
    .hw_irq               (hw_irq),
    .next_src_sel_hi      (next_src_sel_hi),
    .next_src_sel_lo      (next_src_sel_lo),
    .status_out           (status_out),
    .stack_ptr_out        (stack_ptr_out)
  );
  alu_flag_model u_alu (.opa(opa), .opb(opb), .flags(alu_flags));

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (i == 20) mismatches++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // code 5 is the only status-changing code once masks are set
  task automatic load(input int p);
    @(posedge pclk);
    opa <= ta[p];
    opb <= tb2[p];
    low_instruction_bits <= 6'h05;
    @(posedge pclk);
    low_instruction_bits <= 6'h00;
    @(posedge pclk);
    chk(status_out, tf[p]);
  endtask

  task automatic stack_op(input logic pp);
    @(posedge pclk);
    stack_enable_n <= 0;
    push_pop <= pp;
    @(posedge pclk);
    stack_enable_n <= 1;
    repeat (2) @(posedge pclk);
  endtask

  // the pin is seen three to four edges late; no software op meanwhile
  task automatic irq_push;
    @(posedge pclk);
    hw_irq <= 1;
    repeat (2) @(posedge pclk);
    hw_irq <= 0;
    repeat (6) @(posedge pclk);
  endtask

  function automatic logic [1:0] exp_src(logic [3:0] f, logic [2:0] s,
                                          logic d);
    logic [5:0] c;
    c = {f[3], f[2], f[1], !f[1], f[0], !f[0]};
    if (s > 3'h5) return {!d, s[0] ^ d};
    return {2{c[s]}};
  endfunction

  task automatic t_regs;
    apb(0, 8'h00, 32'h0);
    chk(r, 32'hFFFFFFFF);
    apb(1, 8'h00, 32'h00000020);
    apb(1, 8'h04, 32'h0);
    apb(0, 8'h00, 32'h0);
    chk(r, 32'h00000020);
    apb(0, 8'h0C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    load(1);
    @(posedge pclk);
    opa <= 16'h0;
    low_instruction_bits <= 6'h04;
    repeat (2) @(posedge pclk);
    low_instruction_bits <= 6'h00;
    chk(status_out, 4'h5);
    apb(1, 8'h08, 32'hFF);
    apb(0, 8'h08, 32'h0);
    chk(r, 32'h00000005);
  endtask

  task automatic t_branch;
    for (int p = 0; p < 5; p++) begin
      load(p);
      for (int s = 0; s < 16; s++) begin
        @(posedge pclk);
        cond_sel <= s[2:0];
        branch_bit_d <= s[3];
        repeat (2) @(posedge pclk);
        chk({next_src_sel_hi, next_src_sel_lo},
            exp_src(tf[p], s[2:0], s[3]));
      end
    end
  endtask

  // a lone pop at the bottom, four pushes and an interrupt push at the top
  task automatic t_stack;
    stack_op(0);
    chk(stack_ptr_out, 4'h0);
    chk(status_out, 4'h0);
    for (int k = 0; k < 5; k++) begin
      load(k);
      if (k < 4) stack_op(1);
      else irq_push;
      chk(stack_ptr_out, k < 4 ? 4'hF >> (3 - k) : 4'hF);
    end
    for (int k = 0; k < 4; k++) begin
      stack_op(0);
      chk(stack_ptr_out, pe[k]);
      chk(status_out, se[k]);
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    chk({status_out, stack_ptr_out}, 32'h0);
    presetn <= 1;
    t_regs;
    t_branch;
    t_stack;
    irq_push;
    chk(stack_ptr_out, 4'h1);
    apb(0, 8'h08, 32'h0);
    chk(r, 32'h00000011);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk(stack_ptr_out, 4'h0);
    presetn <= 1;
    print_verdict;
  end
endmodule
